/* hdl/cbbc_pkg.sv */
/*
 * cbbc_pkg: opcodes, field positions, widths, reset values and state codes shared by the
 * conditional branch / bit clear execution unit.
 * Assumes: 16-bit instruction words, 8-bit data path, 12-bit data address.
 */
package cbbc_pkg;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    // upper byte encodings of the conditional branches
    localparam logic [7:0] OP_BR_CARRY = 8'hE2;
    localparam logic [7:0] OP_BR_NOT_CARRY = 8'hE3;
    localparam logic [7:0] OP_BR_NOT_OVF = 8'hE5;
    localparam logic [7:0] OP_BR_NEG = 8'hE6;
    localparam logic [7:0] OP_BR_NOT_NEG = 8'hE7;
    // top nibble of the bit clear word
    localparam logic [3:0] OP_CLR_BIT = 4'h9;
    // field positions
    localparam int OPC_HI = 15;
    localparam int BIT_LO = 9;
    localparam int ACC_POS = 8;
    // counter reset value and access bank mapping
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [3:0] BANK_ACCESS = 4'h0;
    localparam logic [3:0] BANK_SFR = 4'hF;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    // program counter step of one instruction word, in bytes
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_FLUSH = 2'b01
    } cbbc_state_e;
endpackage

/* hdl/cbbc_exec.sv */
/*
 * cbbc_exec: executes the conditional relative branches on carry, negative
 * and overflow, and the single-bit clear of a data register.
 * Assumes: one instruction word presented per instruction cycle with
 * instr_valid_i; data memory read is combinational (rd_data_i answers
 * data_addr_o in the same cycle); the core's flags come in as levels.
 */
// Operation
// - Upper byte E2 branches when carry is set, E3 when carry is clear, offset in low byte.
// - Upper byte E6 branches when negative is set, E7 when negative is clear.
// - Upper byte E5 branches only when the overflow flag is clear.
// - The 8-bit offset is signed two's complement and is doubled to a byte offset.
// - The target is the branch address plus two plus twice the offset.
// - A skipped branch takes one cycle with no write; a taken one writes the counter, then idles a cycle.
// - Words 1001 bbba ffff ffff clear bit b of register f and keep the other bits.
// - With access bit 0 the access bank is addressed and the bank select register is ignored.
// - With access bit 1 the address is the bank select register joined to the 8-bit address.
`timescale 1ns/1ps
`default_nettype none
module cbbc_exec
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // instruction from fetch
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [cbbc_pkg::PC_W-1:0] instr_addr_i,
    // status flags (read only here)
    input wire logic carry_i,
    input wire logic negative_i,
    input wire logic overflow_i,
    // bank select register contents
    input wire logic [3:0] bank_select_register_i,
    // data memory
    input wire logic [7:0] rd_data_i,
    output logic [cbbc_pkg::DADDR_W-1:0] data_addr_o,
    output logic data_wr_o,
    output logic [7:0] wr_data_o,
    // program counter load and pipeline
    output logic pc_load_o,
    output logic [cbbc_pkg::PC_W-1:0] program_counter_o,
    output logic flush_o,
    output logic busy_o
);
    // two-cycle taken branch sequencing
    cbbc_pkg::cbbc_state_e state;
    cbbc_pkg::cbbc_state_e next_state;

    // registered counter load and the value it carries
    logic [cbbc_pkg::PC_W-1:0] program_counter;
    logic [cbbc_pkg::PC_W-1:0] next_program_counter;
    logic pc_load;
    logic next_pc_load;

    // decoded instruction fields
    logic [7:0] opc;
    logic [3:0] opc_nibble;
    logic [7:0] offset;
    logic [2:0] bit_sel;
    logic access_bit;
    logic [7:0] reg_addr;

    // decode results
    logic accept;
    logic is_branch;
    logic cond_true;
    logic take;
    logic is_clr;
    logic [cbbc_pkg::PC_W-1:0] target;
    logic [3:0] access_bank;
    logic [3:0] bank;

    // condition of a conditional branch opcode; any other opcode yields zero,
    // so an unknown word can never move the counter
    function automatic logic branch_cond
    (
        input logic [7:0] op,
        input logic carry,
        input logic negative,
        input logic overflow
    );
        logic result;
        result = 1'h0;
        case (op)
            cbbc_pkg::OP_BR_CARRY:
                result = carry;
            cbbc_pkg::OP_BR_NOT_CARRY:
                result = !carry;
            cbbc_pkg::OP_BR_NEG:
                result = negative;
            cbbc_pkg::OP_BR_NOT_NEG:
                result = !negative;
            cbbc_pkg::OP_BR_NOT_OVF:
                result = !overflow;
            default:
                result = 1'h0;
        endcase
        return result;
    endfunction

    // true for the five conditional branch opcodes handled here
    function automatic logic is_branch_op
    (
        input logic [7:0] op
    );
        logic hit;
        hit = 1'h0;
        case (op)
            cbbc_pkg::OP_BR_CARRY,
            cbbc_pkg::OP_BR_NOT_CARRY,
            cbbc_pkg::OP_BR_NEG,
            cbbc_pkg::OP_BR_NOT_NEG,
            cbbc_pkg::OP_BR_NOT_OVF:
                hit = 1'h1;
            default:
                hit = 1'h0;
        endcase
        return hit;
    endfunction

    // sign extend the 8-bit offset, double it to bytes and add it to the
    // advanced counter; the sum wraps at the counter width
    function automatic logic [cbbc_pkg::PC_W-1:0] rel_target
    (
        input logic [cbbc_pkg::PC_W-1:0] base,
        input logic [7:0] off
    );
        logic [cbbc_pkg::PC_W-1:0] byte_off;
        byte_off = {{(cbbc_pkg::PC_W - 9){off[7]}}, off, 1'h0};
        return base + cbbc_pkg::PC_STEP + byte_off;
    endfunction

    // force one bit low and keep the other seven as read
    function automatic logic [7:0] clear_bit
    (
        input logic [7:0] value,
        input logic [2:0] pos
    );
        logic [7:0] mask;
        mask = ~(8'h01 << pos);
        return value & mask;
    endfunction

    // access bank: low half of the address space maps to bank 0, high half
    // to the top bank, so common registers are reached without the bank select
    function automatic logic [3:0] access_bank_of
    (
        input logic [7:0] addr
    );
        logic [3:0] sel;
        sel = (addr < cbbc_pkg::ACCESS_SPLIT) ? cbbc_pkg::BANK_ACCESS : cbbc_pkg::BANK_SFR;
        return sel;
    endfunction

    // instruction field decode; offset and register address share the low byte
    assign opc = instr_i[cbbc_pkg::OPC_HI -: 8];
    assign opc_nibble = instr_i[cbbc_pkg::OPC_HI -: 4];
    assign offset = instr_i[7:0];
    assign bit_sel = instr_i[cbbc_pkg::BIT_LO +: 3];
    assign access_bit = instr_i[cbbc_pkg::ACC_POS];
    assign reg_addr = instr_i[7:0];

    // a word is taken only while no flush is pending; words offered in the
    // flush slot are dropped, which is what turns that cycle into a no-op
    assign accept = instr_valid_i && (state == cbbc_pkg::ST_EXEC);

    // branch decision; the flags are only read here, never written
    assign is_branch = is_branch_op(opc);
    assign cond_true = is_branch && branch_cond(opc, carry_i, negative_i, overflow_i);
    assign take = accept && cond_true;

    // target from the branch word address, advanced past the branch word inside rel_target
    assign target = rel_target(instr_addr_i, offset);

    // bit clear decode and data address; the access bank ignores the bank select
    assign is_clr = accept && (opc_nibble == cbbc_pkg::OP_CLR_BIT);
    assign access_bank = access_bank_of(reg_addr);
    assign bank = access_bit ? bank_select_register_i : access_bank;

    // data memory path is combinational so the clear closes in one cycle;
    // the price is a longer path through the read data
    assign data_addr_o = {bank, reg_addr};
    assign data_wr_o = is_clr;
    assign wr_data_o = clear_bit(rd_data_i, bit_sel);

    // a taken branch spends its second cycle as a no-op flush
    always_comb
    begin
        next_state = state;
        case (state)
            cbbc_pkg::ST_EXEC:
            begin
                if (take)
                    next_state = cbbc_pkg::ST_FLUSH;
            end
            cbbc_pkg::ST_FLUSH:
                next_state = cbbc_pkg::ST_EXEC;
            default:
                next_state = cbbc_pkg::ST_EXEC;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state <= cbbc_pkg::ST_EXEC;
        else
            state <= next_state;
    end

    // next counter values: a taken branch loads the target for one cycle,
    // otherwise the last target stays on the port
    assign next_pc_load = take;
    assign next_program_counter = take ? target : program_counter;

    // registered counter load: written in the first cycle of a taken branch
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            program_counter <= cbbc_pkg::PC_RST;
            pc_load <= 1'h0;
        end
        else
        begin
            program_counter <= next_program_counter;
            pc_load <= next_pc_load;
        end
    end

    assign pc_load_o = pc_load;
    assign program_counter_o = program_counter;
    // skipped branches raise nothing; the prefetched word is dropped while flushing
    assign flush_o = (state == cbbc_pkg::ST_FLUSH);
    assign busy_o = (state != cbbc_pkg::ST_EXEC);
endmodule
`default_nettype wire

/* tb/cbbc_monitor.sv */
/*
 * cbbc_monitor: concurrent checks of branch timing, targets and the bit clear path.
 * Assumes: bound into every cbbc_exec instance and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module cbbc_monitor
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // instruction and flags
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [cbbc_pkg::PC_W-1:0] instr_addr_i,
    input wire logic carry_i,
    input wire logic negative_i,
    input wire logic overflow_i,
    input wire logic [3:0] bank_select_register_i,
    // data memory side
    input wire logic [7:0] rd_data_i,
    input wire logic [cbbc_pkg::DADDR_W-1:0] data_addr_o,
    input wire logic data_wr_o,
    input wire logic [7:0] wr_data_o,
    // counter and pipeline
    input wire logic pc_load_o,
    input wire logic [cbbc_pkg::PC_W-1:0] program_counter_o,
    input wire logic flush_o,
    input wire logic busy_o
);
    // decode of what the design should accept this cycle
    wire [7:0] op = instr_i[15:8];
    wire ok = instr_valid_i && !busy_o;
    wire clr = ok && instr_i[15:12] == cbbc_pkg::OP_CLR_BIT;
    wire br = ok && op inside {8'hE2, 8'hE3, 8'hE5, 8'hE6, 8'hE7};
    wire tk = br && (op == 8'hE2 ? carry_i : op == 8'hE3 ? !carry_i : op == 8'hE6 ? negative_i :
        op == 8'hE7 ? !negative_i : !overflow_i);
    wire [cbbc_pkg::PC_W-1:0] tgt = instr_addr_i + 21'h000002 + {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_wr; data_wr_o == clr; endproperty
    a_wr: assert property (p_wr) else $error("write strobe wrong");
    property p_dat; clr |-> wr_data_o == (rd_data_i & ~(8'h01 << instr_i[11:9])); endproperty
    a_dat: assert property (p_dat) else $error("cleared data wrong");
    property p_acc; clr && !instr_i[8] |-> data_addr_o == {instr_i[7] ? 4'hF : 4'h0, instr_i[7:0]}; endproperty
    a_acc: assert property (p_acc) else $error("access bank address wrong");
    property p_bank; clr && instr_i[8] |-> data_addr_o == {bank_select_register_i, instr_i[7:0]}; endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");
    property p_tgt; tk |=> program_counter_o == $past(tgt); endproperty
    a_tgt: assert property (p_tgt) else $error("branch target wrong");
    property p_two; tk |=> pc_load_o && flush_o && busy_o ##1 !pc_load_o && !flush_o && !busy_o; endproperty
    a_two: assert property (p_two) else $error("taken branch length wrong");
    property p_skip; br && !tk |=> !pc_load_o && !busy_o; endproperty
    a_skip: assert property (p_skip) else $error("skipped branch loaded");
    property p_cause; pc_load_o |-> $past(tk); endproperty
    a_cause: assert property (p_cause) else $error("load without taken branch");
    c_tk: cover property (tk);
    c_skip: cover property (br && !tk);
    c_acc: cover property (clr && !instr_i[8]);
    c_banked: cover property (clr && instr_i[8]);
endmodule
bind cbbc_exec cbbc_monitor cbbc_monitor_i
(
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .instr_addr_i(instr_addr_i),
    .carry_i(carry_i),
    .negative_i(negative_i),
    .overflow_i(overflow_i),
    .bank_select_register_i(bank_select_register_i),
    .rd_data_i(rd_data_i),
    .data_addr_o(data_addr_o),
    .data_wr_o(data_wr_o),
    .wr_data_o(wr_data_o),
    .pc_load_o(pc_load_o),
    .program_counter_o(program_counter_o),
    .flush_o(flush_o),
    .busy_o(busy_o)
);
`default_nettype wire

/* tb/cbbc_dmem.sv */
/* data memory model: combinational read, write on the clock; every byte starts at FF */
`timescale 1ns/1ps
`default_nettype none
module cbbc_dmem(input wire logic core_clk_i, wr_i, input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i, output logic [7:0] rdata_o);
    logic [7:0] mem [0:4095];
    // all ones at start so any cleared bit shows
    initial for (int i = 0; i < 4096; i++) mem[i] = 8'hFF;
    assign rdata_o = mem[addr_i];
    always @(posedge core_clk_i) if (wr_i) mem[addr_i] <= wdata_i;
endmodule
`default_nettype wire

/* tb/tb.sv */
/* bench for cbbc_exec: branch and bit clear sequences against the cbbc_dmem model */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0, rst_b = 1'h0, vld = 1'h0, c = 1'h1, n = 1'h0, v = 1'h0, ld, wr;
    logic [15:0] ins = 16'h0000;
    logic [20:0] pa = 21'h000100, pc;
    logic [3:0] bank_sel = 4'h3;
    logic [7:0] rd, wd;
    logic [11:0] da;
    int num_errors = 0, n_compared = 0;
    cbbc_exec cbbc_exec_i(.core_clk_i(clk), .rst_b_i(rst_b), .instr_valid_i(vld), .instr_i(ins), .instr_addr_i(pa),
        .carry_i(c), .negative_i(n), .overflow_i(v), .bank_select_register_i(bank_sel), .rd_data_i(rd), .data_addr_o(da),
        .data_wr_o(wr), .wr_data_o(wd), .pc_load_o(ld), .program_counter_o(pc), .flush_o(), .busy_o());
    cbbc_dmem cbbc_dmem_i(.core_clk_i(clk), .wr_i(wr), .addr_i(da), .wdata_i(wd), .rdata_o(rd));
    initial forever #2.5 clk = ~clk;
    task chk(input string nm, input logic [20:0] e, s);
        n_compared++;
        if (e !== s) begin num_errors++; $display("Error %s exp %h got %h", nm, e, s); end
    endtask
    // one instruction, then the slot a taken branch leaves empty
    task go(input logic [15:0] w, input logic tk);
        logic [20:0] t;
        t = pa + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0};
        vld <= 1'h1;
        ins <= w;
        @(posedge clk);
        vld <= 1'h0;
        #1;
        chk("load", tk, ld);
        if (tk) chk("target", t, pc);
        @(posedge clk);
    endtask
    task clr(input logic [2:0] b, input logic a, input logic [7:0] f, input logic [11:0] ea);
        go({4'h9, b, a, f}, 1'h0);
        chk("bit", 8'(~(8'h01 << b)), cbbc_dmem_i.mem[ea]);
    endtask
    task end_of_test;
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        go(16'hE205, 1'h1); go(16'hE3FF, 1'h0); go(16'hE680, 1'h0);
        go(16'hE77F, 1'h1); go(16'hE500, 1'h1);
        c <= 1'h0;
        n <= 1'h1;
        v <= 1'h1;
        pa <= 21'h001F00;
        @(posedge clk);
        go(16'hE201, 1'h0); go(16'hE380, 1'h1); go(16'hE6FE, 1'h1);
        go(16'hE701, 1'h0); go(16'hE505, 1'h0);
        clr(3'h7, 1'h0, 8'h10, 12'h010); clr(3'h0, 1'h0, 8'h90, 12'hF90);
        clr(3'h4, 1'h1, 8'h22, 12'h322);
        // a clear offered in the flush slot of a taken branch must be dropped
        vld <= 1'h1;
        ins <= 16'hE604;
        @(posedge clk);
        ins <= 16'h9E44;
        @(posedge clk);
        vld <= 1'h0;
        @(posedge clk);
        chk("dropped", 21'h0000FF, cbbc_dmem_i.mem[12'h044]);
        end_of_test;
    end
    initial begin #20000; num_errors++; end_of_test; end
endmodule
`default_nettype wire
